// File: verilog/sam_params.svh
// constants of the supply alarm monitor: offsets, field positions, reset values, timing counts
`ifndef SAM_PARAMS_SVH
`define SAM_PARAMS_SVH

// reconfiguration port register offsets
`define SAM_OFF_AUX_RESULT 7'h02
`define SAM_OFF_AVG_CFG 7'h40
`define SAM_OFF_SEQ_CFG 7'h41
`define SAM_OFF_DIV_CFG 7'h42
`define SAM_OFF_SEL_LO 7'h48
`define SAM_OFF_SEL_HI 7'h49
`define SAM_OFF_AVGEN_LO 7'h4a
`define SAM_OFF_AVGEN_HI 7'h4b
`define SAM_OFF_MODE_LO 7'h4c
`define SAM_OFF_MODE_HI 7'h4d
`define SAM_OFF_ACQ_LO 7'h4e
`define SAM_OFF_ACQ_HI 7'h4f
`define SAM_OFF_UPPER 7'h52
`define SAM_OFF_LOWER 7'h56

// field positions
`define SAM_BIT_AVG_HI 13
`define SAM_BIT_AVG_LO 12
`define SAM_BIT_SEQ_HI 13
`define SAM_BIT_SEQ_LO 12
`define SAM_BIT_GAIN_CAL 7
`define SAM_BIT_OFFSET_CAL 6
`define SAM_BIT_AUX_ALM_DIS 3
`define SAM_DIV_MSB 15
`define SAM_DIV_LSB 8
`define SAM_LIMIT_MSB 15
`define SAM_LIMIT_LSB 6

// reset values of the configuration registers
`define SAM_RST_AVG_CFG 16'h1000
`define SAM_RST_SEQ_CFG 16'h20c7
`define SAM_RST_DIV_CFG 16'h0a00
`define SAM_RST_SEL_LO 16'h0401
`define SAM_RST_AVGEN_LO 16'h0400
`define SAM_RST_UPPER 16'he000
`define SAM_RST_LOWER 16'hcaaa

// timing and channel constants
`define SAM_CONV_CYCLES 5'h1a
`define SAM_MIN_DIVIDE 8'h02
`define SAM_CAL_CHANNEL 5'h08
`define SAM_AUX_CHANNEL 5'h02
`define SAM_CAL_REFERENCE 16'h8000

`endif

// File: verilog/sam_pkg.sv
// types shared by the supply alarm monitor modules
package sam_pkg;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        st_halt = 3'b001,
        st_scan = 3'b010,
        st_conv = 3'b100
    } sam_seq_state_t;

    // one reconfiguration port request
    typedef struct packed {
        logic enable;
        logic write_enable;
        logic [6:0] address;
        logic [15:0] data_in;
    } sam_port_req_t;

    // reconfiguration port answer
    typedef struct packed {
        logic [15:0] data_out;
        logic data_ready;
    } sam_port_rsp_t;

endpackage

// File: verilog/sam_clkdiv.sv
// converter clock enable derived from the port clock by an integer divider
`timescale 1ns/1ps
`include "sam_params.svh"
module sam_clkdiv (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] divide,
    output logic tick
);
    import sam_pkg::*;

    // whole state of the divider
    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } sam_div_state_t;

    sam_div_state_t state_reg; // registered state
    sam_div_state_t state_next; // next state
    logic [7:0] limit; // effective divide ratio

    // ratios below two cannot make a half-rate enable, so they are raised to two
    always_comb
    begin
        state_next = state_reg;
        limit = (divide < `SAM_MIN_DIVIDE) ? `SAM_MIN_DIVIDE : divide;
        state_next.tick = 1'b0;
        if (state_reg.count >= limit - 8'h01)
        begin
            state_next.count = 8'h00;
            state_next.tick = 1'b1;
        end
        else
        begin
            state_next.count = state_reg.count + 8'h01;
        end
    end

    // register the divider
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign tick = state_reg.tick;
endmodule // sam_clkdiv

// File: verilog/sam_limit_cmp.sv
// window comparator on the top ten bits of the stored supply result
`timescale 1ns/1ps
`include "sam_params.svh"
module sam_limit_cmp (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] value,
    input wire logic [15:0] upper,
    input wire logic [15:0] lower,
    input wire logic disable_alarm,
    output logic alarm
);
    import sam_pkg::*;

    // whole state of the comparator
    typedef struct packed {
        logic alarm;
    } sam_cmp_state_t;

    sam_cmp_state_t state_reg; // registered state
    sam_cmp_state_t state_next; // next state

    // outside either limit raises the alarm, back inside clears it
    always_comb
    begin
        state_next.alarm = ~disable_alarm &&
            ((value[`SAM_LIMIT_MSB:`SAM_LIMIT_LSB] > upper[`SAM_LIMIT_MSB:`SAM_LIMIT_LSB]) ||
             (value[`SAM_LIMIT_MSB:`SAM_LIMIT_LSB] < lower[`SAM_LIMIT_MSB:`SAM_LIMIT_LSB]));
    end

    // register the alarm so the pin comes from a flip-flop
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign alarm = state_reg.alarm;
endmodule // sam_limit_cmp

// File: verilog/sam_monitor.sv
// supply alarm monitor: sequencer, averaging, result store and reconfiguration port
// Functional notes
// - enable high: capture address, drive register data
// - channel output shows converted channel at end
// - result stored at port address of channel
// - end-of-sequence pulses one cycle per pass
// - ready rises with valid data after read
// - busy high throughout every conversion
// - alarm high outside limits, low inside
// - averaging bits 01 give sixteen-sample average
// - sequence bits 10 run automatic sequence
// - calibration bits apply offset and gain
// - alarm disable bit one suppresses alarm
// - port clock divided, conversion 26 converter cycles
// - only selected channels are converted
// - limits compared on top ten bits
// - no port clock: monitoring continues, port frozen
`timescale 1ns/1ps
`include "sam_params.svh"
module sam_monitor (
    input wire logic ref_clk,
    input wire logic reset,
    input wire sam_pkg::sam_port_req_t port_req,
    input wire logic port_clock_present,
    input wire logic [15:0] conv_sample,
    output sam_pkg::sam_port_rsp_t port_rsp,
    output logic [4:0] channel,
    output logic [4:0] conv_mux_address,
    output logic end_of_sequence,
    output logic busy,
    output logic aux_alarm
);
    import sam_pkg::*;

    // whole state of the monitor
    typedef struct packed {
        logic [15:0] avg_cfg; // averaging_config
        logic [15:0] seq_cfg; // sequence_calib_alarm_config
        logic [15:0] div_cfg; // clock_divider_config
        logic [15:0] sel_lo; // sequence_channel_select_lo
        logic [15:0] sel_hi; // sequence_channel_select_hi
        logic [15:0] avgen_lo; // channel_average_enable_lo
        logic [15:0] avgen_hi; // channel_average_enable_hi
        logic [15:0] mode_lo; // input_mode_select_lo
        logic [15:0] mode_hi; // input_mode_select_hi
        logic [15:0] acq_lo; // acquisition_time_lo
        logic [15:0] acq_hi; // acquisition_time_hi
        logic [15:0] upper; // aux_supply_upper_limit
        logic [15:0] lower; // aux_supply_lower_limit
        logic [31:0][15:0] status; // results indexed by mux address
        sam_seq_state_t st; // sequencer state
        logic [4:0] idx; // sequence bit position being visited
        logic [4:0] cyc; // converter cycles into this conversion
        logic [7:0] navg; // samples already summed
        logic [23:0] acc; // averaging accumulator
        logic [15:0] cal_err; // signed calibration error
        logic [4:0] mux; // channel under conversion
        logic [4:0] channel; // last converted channel
        logic busy;
        logic eos;
        sam_port_rsp_t rsp;
    } sam_mon_state_t;

    sam_mon_state_t state_reg; // registered state
    sam_mon_state_t state_next; // next state
    logic conv_tick; // converter clock enable
    logic [31:0] sel_all; // sequence selection, bit per position
    logic [31:0] avgen_all; // averaging enable, bit per position
    logic [1:0] avg_sel; // averaging select field
    logic auto_mode; // automatic sequence selected
    logic [7:0] avg_last; // index of last sample in an average
    logic [3:0] avg_shift; // divide shift of the average
    logic [4:0] adv_idx; // next position of the walk
    logic adv_eos; // walk wraps: pass finished
    logic [15:0] corrected; // sample after calibration
    logic [23:0] acc_sum; // accumulator plus this sample

    // sequence bit position to mux address; position 0 is the calibration channel
    function automatic logic [4:0] sam_pos_to_chan(input logic [4:0] pos);
        logic [4:0] c;
        c = pos;
        if (pos < 5'h08)
        begin
            c = pos + 5'h08;
        end
        else if (pos < 5'h10)
        begin
            c = pos - 5'h08;
        end
        return c;
    endfunction

    // offset and gain correction, clamped to the code range
    function automatic logic [15:0] sam_correct(input logic [15:0] v, input logic [15:0] err,
                                                input logic off_en, input logic gain_en);
        logic signed [33:0] t;
        logic signed [33:0] e;
        t = {18'h00000, v};
        e = 34'(signed'(err));
        if (off_en)
        begin
            t = t - e;
        end
        if (gain_en)
        begin
            t = t - ((t * e) >>> 15);
        end
        if (t < 0)
        begin
            return 16'h0000;
        end
        else if (t > 34'sh0ffff)
        begin
            return 16'hffff;
        end
        return t[15:0];
    endfunction

    // register read decode; unmapped addresses read zero
    function automatic logic [15:0] sam_read(input sam_mon_state_t s, input logic [6:0] a);
        logic [15:0] d;
        d = 16'h0000;
        if (a[6:5] == 2'b00)
        begin
            d = s.status[a[4:0]];
        end
        else
        begin
            case (a)
                `SAM_OFF_AVG_CFG: d = s.avg_cfg;
                `SAM_OFF_SEQ_CFG: d = s.seq_cfg;
                `SAM_OFF_DIV_CFG: d = s.div_cfg;
                `SAM_OFF_SEL_LO: d = s.sel_lo;
                `SAM_OFF_SEL_HI: d = s.sel_hi;
                `SAM_OFF_AVGEN_LO: d = s.avgen_lo;
                `SAM_OFF_AVGEN_HI: d = s.avgen_hi;
                `SAM_OFF_MODE_LO: d = s.mode_lo;
                `SAM_OFF_MODE_HI: d = s.mode_hi;
                `SAM_OFF_ACQ_LO: d = s.acq_lo;
                `SAM_OFF_ACQ_HI: d = s.acq_hi;
                `SAM_OFF_UPPER: d = s.upper;
                `SAM_OFF_LOWER: d = s.lower;
                default: d = 16'h0000;
            endcase
        end
        return d;
    endfunction

    // converter clock enable from the divider field
    sam_clkdiv u_sam_clkdiv (
        .ref_clk(ref_clk),
        .reset(reset),
        .divide(state_reg.div_cfg[`SAM_DIV_MSB:`SAM_DIV_LSB]),
        .tick(conv_tick)
    );

    // auxiliary supply window alarm
    sam_limit_cmp u_sam_limit_cmp (
        .ref_clk(ref_clk),
        .reset(reset),
        .value(state_reg.status[`SAM_AUX_CHANNEL]),
        .upper(state_reg.upper),
        .lower(state_reg.lower),
        .disable_alarm(state_reg.seq_cfg[`SAM_BIT_AUX_ALM_DIS]),
        .alarm(aux_alarm)
    );

    // decoded configuration
    always_comb
    begin
        sel_all = {state_reg.sel_hi, state_reg.sel_lo};
        avgen_all = {state_reg.avgen_hi, state_reg.avgen_lo};
        avg_sel = {state_reg.avg_cfg[`SAM_BIT_AVG_HI], state_reg.avg_cfg[`SAM_BIT_AVG_LO]};
        auto_mode = state_reg.seq_cfg[`SAM_BIT_SEQ_HI] & ~state_reg.seq_cfg[`SAM_BIT_SEQ_LO];
        // 01 sixteen, 10 sixty-four, 11 two hundred fifty-six samples
        unique case (avg_sel)
            2'b01: begin avg_last = 8'h0f; avg_shift = 4'h4; end
            2'b10: begin avg_last = 8'h3f; avg_shift = 4'h6; end
            2'b11: begin avg_last = 8'hff; avg_shift = 4'h8; end
            2'b00: begin avg_last = 8'h00; avg_shift = 4'h0; end
        endcase
        adv_idx = state_reg.idx + 5'h01;
        adv_eos = (state_reg.idx == 5'h1f) && (sel_all != 32'h00000000);
        corrected = sam_correct(conv_sample, state_reg.cal_err,
                                state_reg.seq_cfg[`SAM_BIT_OFFSET_CAL],
                                state_reg.seq_cfg[`SAM_BIT_GAIN_CAL]);
        acc_sum = state_reg.acc + {8'h00, corrected};
    end

    // next state: port access and sequencer
    always_comb
    begin
        state_next = state_reg;
        state_next.eos = 1'b0;
        state_next.rsp.data_ready = 1'b0;
        // port is only served while its clock is present
        if (port_req.enable && port_clock_present)
        begin
            state_next.rsp.data_ready = 1'b1;
            if (port_req.write_enable)
            begin
                // writes keep the previous data output
                case (port_req.address)
                    `SAM_OFF_AVG_CFG: state_next.avg_cfg = port_req.data_in;
                    `SAM_OFF_SEQ_CFG: state_next.seq_cfg = port_req.data_in;
                    `SAM_OFF_DIV_CFG: state_next.div_cfg = port_req.data_in;
                    `SAM_OFF_SEL_LO: state_next.sel_lo = port_req.data_in;
                    `SAM_OFF_SEL_HI: state_next.sel_hi = port_req.data_in;
                    `SAM_OFF_AVGEN_LO: state_next.avgen_lo = port_req.data_in;
                    `SAM_OFF_AVGEN_HI: state_next.avgen_hi = port_req.data_in;
                    `SAM_OFF_MODE_LO: state_next.mode_lo = port_req.data_in;
                    `SAM_OFF_MODE_HI: state_next.mode_hi = port_req.data_in;
                    `SAM_OFF_ACQ_LO: state_next.acq_lo = port_req.data_in;
                    `SAM_OFF_ACQ_HI: state_next.acq_hi = port_req.data_in;
                    `SAM_OFF_UPPER: state_next.upper = port_req.data_in;
                    `SAM_OFF_LOWER: state_next.lower = port_req.data_in;
                    default: state_next.avg_cfg = state_reg.avg_cfg; // results are read-only
                endcase
            end
            else
            begin
                state_next.rsp.data_out = sam_read(state_reg, port_req.address);
            end
        end
        unique case (state_reg.st)
            // other sequence modes leave the converter idle
            st_halt:
            begin
                if (auto_mode)
                begin
                    state_next.st = st_scan;
                end
            end
            // visit one sequence position a cycle, skipping unselected ones
            st_scan:
            begin
                if (!auto_mode)
                begin
                    state_next.st = st_halt;
                end
                else if (sel_all[state_reg.idx])
                begin
                    state_next.st = st_conv;
                    state_next.busy = 1'b1;
                    state_next.cyc = 5'h00;
                    state_next.mux = sam_pos_to_chan(state_reg.idx);
                end
                else
                begin
                    state_next.idx = adv_idx;
                    state_next.eos = adv_eos;
                end
            end
            // count converter cycles; finish on the last one
            st_conv:
            begin
                if (conv_tick && state_reg.cyc == `SAM_CONV_CYCLES - 5'h01)
                begin
                    state_next.st = st_scan;
                    state_next.busy = 1'b0;
                    state_next.channel = state_reg.mux;
                    if (state_reg.mux == `SAM_CAL_CHANNEL)
                    begin
                        // calibration reading sets the error used on the supply channels
                        state_next.cal_err = conv_sample - `SAM_CAL_REFERENCE;
                        state_next.status[state_reg.mux] = conv_sample;
                        state_next.idx = adv_idx;
                        state_next.eos = adv_eos;
                    end
                    else if (avgen_all[state_reg.idx] && avg_sel != 2'b00)
                    begin
                        // repeat this channel until the average is complete
                        if (state_reg.navg == avg_last)
                        begin
                            state_next.status[state_reg.mux] = 16'(acc_sum >> avg_shift);
                            state_next.acc = 24'h000000;
                            state_next.navg = 8'h00;
                            state_next.idx = adv_idx;
                            state_next.eos = adv_eos;
                        end
                        else
                        begin
                            state_next.acc = acc_sum;
                            state_next.navg = state_reg.navg + 8'h01;
                        end
                    end
                    else
                    begin
                        state_next.status[state_reg.mux] = corrected;
                        state_next.idx = adv_idx;
                        state_next.eos = adv_eos;
                    end
                end
                else if (conv_tick)
                begin
                    state_next.cyc = state_reg.cyc + 5'h01;
                end
            end
        endcase
    end

    // register the whole state; synchronous reset loads the setup values
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_reg <= '0;
            state_reg.avg_cfg <= `SAM_RST_AVG_CFG;
            state_reg.seq_cfg <= `SAM_RST_SEQ_CFG;
            state_reg.div_cfg <= `SAM_RST_DIV_CFG;
            state_reg.sel_lo <= `SAM_RST_SEL_LO;
            state_reg.avgen_lo <= `SAM_RST_AVGEN_LO;
            state_reg.upper <= `SAM_RST_UPPER;
            state_reg.lower <= `SAM_RST_LOWER;
            state_reg.st <= st_halt;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign port_rsp = state_reg.rsp;
    assign channel = state_reg.channel;
    assign conv_mux_address = state_reg.mux;
    assign end_of_sequence = state_reg.eos;
    assign busy = state_reg.busy;

    // length of the current busy period, for the checks below
    logic [11:0] busy_len;
    always_ff @(posedge ref_clk)
    begin
        if (reset || !state_reg.busy)
        begin
            busy_len <= 12'h000;
        end
        else if (busy_len != 12'hfff)
        begin
            busy_len <= busy_len + 12'h001;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence s_read_req;
        port_req.enable && port_clock_present && !port_req.write_enable;
    endsequence
    sequence s_answer;
        port_rsp.data_ready ##1 !port_rsp.data_ready;
    endsequence

    // back-to-back reads are legal, so the one-cycle answer is only asked of a lone read
    a_read_answer: assert property (s_read_req ##1 !port_req.enable |-> s_answer)
        else $error("read not answered by a one-cycle ready");
    a_ready_cause: assert property (port_rsp.data_ready |-> $past(port_req.enable))
        else $error("ready without an enabled access");
    a_port_frozen: assert property (!port_clock_present |=> !port_rsp.data_ready && $stable(port_rsp.data_out))
        else $error("port answered while its clock is absent");
    a_data_hold: assert property (!port_rsp.data_ready |-> $stable(port_rsp.data_out))
        else $error("data output changed without a read");
    a_eos_single: assert property (end_of_sequence |=> !end_of_sequence)
        else $error("end of sequence longer than one cycle");
    // 26 ticks at the fastest divide of two span at least 51 edges; the counter lags by one
    a_busy_min: assert property ($fell(busy) |-> $past(busy_len) >= 12'h032)
        else $error("conversion shorter than 26 converter cycles");
    a_busy_hold: assert property ($rose(busy) |-> busy[*8])
        else $error("busy dropped early in a conversion");
    a_channel_end: assert property ($fell(busy) |-> channel == conv_mux_address)
        else $error("channel output not the converted channel");
    a_alarm_disable: assert property (state_reg.seq_cfg[`SAM_BIT_AUX_ALM_DIS] |=> !aux_alarm)
        else $error("alarm driven while disabled");
endmodule // sam_monitor

// File: verif/sam_fabric_reader.sv
// partner model: fabric logic that chains end of sequence into a port read
`timescale 1ns/1ps
module sam_fabric_reader (
    input wire logic end_of_sequence,
    input wire logic [4:0] channel,
    output sam_pkg::sam_port_req_t req
);
    import sam_pkg::*;
    // one read per pass, at the channel that just finished
    always_comb
    begin
        req.enable = end_of_sequence;
        req.address = {2'b00, channel}; // upper address bits tied low
        req.write_enable = 1'b0; // read-only setup never writes
        req.data_in = 16'h0000;
    end
endmodule // sam_fabric_reader

// File: verif/sam_monitor_bench.sv
// self-checking bench of the supply alarm monitor
`timescale 1ns/1ps
`include "sam_params.svh"
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module sam_monitor_bench;
    import sam_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic port_clock_present = 1'b1;
    logic sel_fab = 1'b0; // partner owns the port while high
    logic [15:0] aux_val = 16'hd555; // aux supply near nominal
    logic [15:0] cal_val = `SAM_CAL_REFERENCE; // calibration channel reading
    logic [15:0] conv_sample;
    sam_port_req_t req_tb = '0;
    sam_port_req_t req_fab;
    sam_port_req_t port_req;
    sam_port_rsp_t port_rsp;
    logic [4:0] channel;
    logic [4:0] conv_mux_address;
    logic end_of_sequence;
    logic busy;
    logic aux_alarm;
    logic [15:0] rdata;
    int bad_count = 0;
    int tests_run = 0;
    int falls;
    int width;
    int wlast;
    // offset and expected reset value; 7f is unmapped, 02 has no result yet
    logic [22:0] regs [11] = '{{7'h40, 16'h1000}, {7'h41, 16'h20c7}, {7'h42, 16'h0a00}, {7'h48, 16'h0401},
        {7'h49, 16'h0000}, {7'h4a, 16'h0400}, {7'h4b, 16'h0000}, {7'h52, 16'he000}, {7'h56, 16'hcaaa},
        {7'h7f, 16'h0000}, {7'h02, 16'h0000}};
    always #25 ref_clk = ~ref_clk;
    // calibration channel reads the reference until the calibration test offsets it
    assign conv_sample = (conv_mux_address == `SAM_CAL_CHANNEL) ? cal_val : aux_val;
    assign port_req = sel_fab ? req_fab : req_tb;
    sam_monitor u_sam_monitor (
        .ref_clk(ref_clk),
        .reset(reset),
        .port_req(port_req),
        .port_clock_present(port_clock_present),
        .conv_sample(conv_sample),
        .port_rsp(port_rsp),
        .channel(channel),
        .conv_mux_address(conv_mux_address),
        .end_of_sequence(end_of_sequence),
        .busy(busy),
        .aux_alarm(aux_alarm)
    );
    sam_fabric_reader u_sam_fabric_reader (
        .end_of_sequence(end_of_sequence),
        .channel(channel),
        .req(req_fab)
    );
    // one-cycle access pulse; ready is looked at in the cycle after the taking edge
    task automatic access(input logic we, input logic [6:0] a, input logic [15:0] d, input logic rdy);
        @(negedge ref_clk);
        req_tb <= '{enable: 1'b1, write_enable: we, address: a, data_in: d};
        @(negedge ref_clk);
        req_tb <= '0;
        `CHK("data_ready", rdy, port_rsp.data_ready)
        rdata = port_rsp.data_out;
    endtask
    // runs to the next end of sequence, counting conversions and their length
    task automatic wait_eos();
        int n;
        falls = 0;
        width = 0;
        for (n = 0; n < 6000 && end_of_sequence !== 1'b1; n++)
        begin
            @(negedge ref_clk);
            if (busy === 1'b1)
                width++;
            else if (width != 0)
            begin
                falls++;
                wlast = width;
                width = 0;
            end
        end
        `CHK("eos_seen", 1'b1, end_of_sequence)
        @(negedge ref_clk);
        `CHK("eos_one_cycle", 1'b0, end_of_sequence)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // watchdog sized about half again above six passes of the sequence
    initial
    begin
        repeat (40000) @(posedge ref_clk);
        bad_count++;
        $display("watchdog expired");
        wrap_up();
    end
    // main sequence
    initial
    begin
        repeat (20) @(negedge ref_clk);
        reset <= 1'b0;
        foreach (regs[i])
        begin
            access(1'b0, regs[i][22:16], 16'h0000, 1'b1);
            `CHK("reset_value", regs[i][15:0], rdata)
        end
        `CHK("alarm_low_result", 1'b1, aux_alarm) // empty result is below the lower limit
        access(1'b1, `SAM_OFF_ACQ_LO, 16'h1234, 1'b1);
        access(1'b0, `SAM_OFF_ACQ_LO, 16'h0000, 1'b1);
        `CHK("rw_back", 16'h1234, rdata)
        access(1'b1, `SAM_OFF_AUX_RESULT, 16'hffff, 1'b1);
        access(1'b0, `SAM_OFF_AUX_RESULT, 16'h0000, 1'b1);
        `CHK("status_ro", 16'h0000, rdata)
        $display("test registers done");
        sel_fab <= 1'b1;
        wait_eos();
        wait_eos();
        `CHK("conv_per_pass", 17, falls) // one calibration plus sixteen aux
        `CHK("busy_len", 1'b1, (wlast >= 250 && wlast <= 261)) // 26 ticks of ten cycles
        `CHK("channel", `SAM_AUX_CHANNEL, channel)
        `CHK("mux_next_pass", `SAM_CAL_CHANNEL, conv_mux_address)
        `CHK("aux_result", 16'hd555, port_rsp.data_out)
        `CHK("alarm_inside", 1'b0, aux_alarm)
        $display("test sequence done");
        port_clock_present <= 1'b0;
        aux_val <= 16'hf000;
        wait_eos();
        wait_eos();
        `CHK("frozen_data", 16'hd555, port_rsp.data_out)
        `CHK("alarm_above", 1'b1, aux_alarm)
        sel_fab <= 1'b0;
        access(1'b0, `SAM_OFF_AUX_RESULT, 16'h0000, 1'b0);
        `CHK("frozen_hold", 16'hd555, rdata)
        port_clock_present <= 1'b1;
        $display("test frozen port done");
        access(1'b1, `SAM_OFF_SEQ_CFG, 16'h20cf, 1'b1);
        repeat (3) @(negedge ref_clk);
        `CHK("alarm_disabled", 1'b0, aux_alarm)
        $display("test alarm disable done");
        // calibration error of 0x10: offset takes 0x10 off, gain takes t*0x10>>15 more
        sel_fab <= 1'b1;
        cal_val <= 16'h8010;
        aux_val <= 16'hd565;
        wait_eos();
        wait_eos();
        `CHK("cal_result", 16'hd53b, port_rsp.data_out)
        $display("test calibration done");
        wrap_up();
    end
endmodule // sam_monitor_bench
